// ===== core/spg_cfg.svh
// Address map, field positions, reset values and tick timing for the strobe block
`ifndef SPG_CFG_SVH
`define SPG_CFG_SVH

`define SPG_NCH          4
`define SPG_AW           8
`define SPG_OFS_CH0      8'h00
`define SPG_OFS_CH1      8'h04
`define SPG_OFS_CH2      8'h08
`define SPG_OFS_CH3      8'h0c
`define SPG_OFS_TICK     8'h10
`define SPG_OFS_ROUTE    8'h14
`define SPG_OFS_UOUT     8'h18
`define SPG_OFS_INS      8'h1c

`define SPG_CH_EN        31
`define SPG_CH_POL       30
`define SPG_CH_LAG_HI    23
`define SPG_CH_LAG_LO    12
`define SPG_CH_WID_HI    11
`define SPG_CH_WID_LO    0
`define SPG_CH_MASK      32'hc0ffffff
`define SPG_TICK_DLY_HI  7
`define SPG_TICK_DLY_LO  0
`define SPG_TICK_DUR_HI  23
`define SPG_TICK_DUR_LO  16
`define SPG_TICK_MASK    32'h00ff00ff
`define SPG_RST_CH       32'h00000000
`define SPG_RST_TICK     32'h00000000
`define SPG_RST_ROUTE    4'h0
`define SPG_RST_UOUT     4'h0

`define SPG_RESP_OKAY    2'h0
`define SPG_RESP_SLVERR  2'h2

// Tick unit of 1/1024 ms is 1024000 ticks per second; the clock is 50 MHz.
// Both are divided by their common factor to give a fractional step.
`define SPG_CLK_HZ       32'h02faf080
`define SPG_TICK_HZ      32'h000fa000
`define SPG_HZ_GCD       32'h00001f40
`define SPG_ACC_STEP     13'((`SPG_TICK_HZ) / (`SPG_HZ_GCD))
`define SPG_ACC_MOD      13'((`SPG_CLK_HZ) / (`SPG_HZ_GCD))
`define SPG_ACC_RST      13'h0000
`define SPG_CNT_ZERO     12'h000
`define SPG_CNT_ONE      12'h001

`endif

// ===== core/spg_pkg.sv
// Types shared by the strobe pulse and port I/O block
`default_nettype none
package spg_pkg;
    typedef enum logic [2:0] {
        SPG_IDLE  = 3'b001,
        SPG_DELAY = 3'b010,
        SPG_PULSE = 3'b100
    } spg_state_t;
endpackage
`default_nettype wire

// ===== core/spg_tick.sv
// Fractional prescaler giving one tick per selectable multiple of 1/1024 ms
`timescale 1ns/1ns
`default_nettype none
`include "spg_cfg.svh"
module spg_tick
    import spg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        restart,
    input  wire logic [7:0]  mult,
    output logic             tick
);
    logic [12:0] acc_r;
    logic [13:0] acc_sum;
    logic        base;
    logic [7:0]  mcnt_r;

    assign acc_sum = {1'b0, acc_r} + {1'b0, `SPG_ACC_STEP};
    assign base    = acc_sum >= {1'b0, `SPG_ACC_MOD};
    assign tick    = base && (mcnt_r == mult);

    // Restart aligns the unit to the phase start, so no phase is cut short
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            acc_r <= `SPG_ACC_RST;
        else if (restart)
            acc_r <= `SPG_ACC_RST;
        else if (base)
            acc_r <= 13'(acc_sum - {1'b0, `SPG_ACC_MOD});
        else
            acc_r <= acc_sum[12:0];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            mcnt_r <= 8'h00;
        else if (restart || tick)
            mcnt_r <= 8'h00;
        else if (base)
            mcnt_r <= 8'(mcnt_r + 8'h01);
    end
endmodule // spg_tick
`default_nettype wire

// ===== core/spg_top.sv
// Four strobe pulse channels, output port routing and parallel I/O over AXI4-Lite
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "spg_cfg.svh"
module spg_top
    import spg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        exposure_start,
    input  wire logic [3:0]  in_port,
    output logic      [3:0]  out_port,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    logic [31:0]      ch_ctrl_r [`SPG_NCH];
    logic [31:0]      tick_sel_r;
    logic [3:0]       route_r;
    logic [3:0]       user_out_r;
    logic [3:0]       in_meta_r;
    logic [3:0]       in_sync_r;
    logic [3:0]       active;
    logic [3:0]       busy;
    logic [3:0]       port_nxt;

    logic             aw_full_r;
    logic [7:0]       aw_addr_r;
    logic             w_full_r;
    logic [31:0]      w_data_r;
    logic [3:0]       w_strb_r;
    logic             wr_en;
    logic             wr_hit;
    logic [31:0]      rd_data;
    logic             rd_hit;

    // Protection bits carry no meaning for this block
    logic             prot_unused;
    assign prot_unused = ^{s_axi_awprot, s_axi_arprot};

    function automatic logic [31:0] spg_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                res[b*8 +: 8] = new_v[b*8 +: 8];
        end
        return res;
    endfunction

    // Write address channel
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_awready <= 1'b1;
            aw_full_r     <= 1'b0;
            aw_addr_r     <= 8'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            s_axi_awready <= 1'b0;
            aw_full_r     <= 1'b1;
            aw_addr_r     <= s_axi_awaddr;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_awready <= 1'b1;
            aw_full_r     <= 1'b0;
        end
    end

    // Write data channel, taken independently of the address
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_wready <= 1'b1;
            w_full_r     <= 1'b0;
            w_data_r     <= 32'h00000000;
            w_strb_r     <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            s_axi_wready <= 1'b0;
            w_full_r     <= 1'b1;
            w_data_r     <= s_axi_wdata;
            w_strb_r     <= s_axi_wstrb;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_wready <= 1'b1;
            w_full_r     <= 1'b0;
        end
    end

    assign wr_en = aw_full_r && w_full_r && !s_axi_bvalid;

    always_comb
    begin
        unique case (aw_addr_r)
            `SPG_OFS_CH0, `SPG_OFS_CH1, `SPG_OFS_CH2, `SPG_OFS_CH3,
            `SPG_OFS_TICK, `SPG_OFS_ROUTE, `SPG_OFS_UOUT, `SPG_OFS_INS:
                wr_hit = 1'b1;
            default:
                wr_hit = 1'b0;
        endcase
    end

    // Write response; unmapped addresses answer with a slave error
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SPG_RESP_OKAY;
        end
        else if (wr_en)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `SPG_RESP_OKAY : `SPG_RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Channel settings, one word per channel
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int n = 0; n < `SPG_NCH; n++)
                ch_ctrl_r[n] <= `SPG_RST_CH;
        end
        else if (wr_en)
        begin
            for (int n = 0; n < `SPG_NCH; n++)
            begin
                if (aw_addr_r == 8'(`SPG_OFS_CH0 + 8'(n * 4)))
                    ch_ctrl_r[n] <= spg_merge(ch_ctrl_r[n], w_data_r, w_strb_r)
                                    & `SPG_CH_MASK;
            end
        end
    end

    // Tick unit select for delay and duration
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tick_sel_r <= `SPG_RST_TICK;
        else if (wr_en && aw_addr_r == `SPG_OFS_TICK)
            tick_sel_r <= spg_merge(tick_sel_r, w_data_r, w_strb_r)
                          & `SPG_TICK_MASK;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            route_r <= `SPG_RST_ROUTE;
        else if (wr_en && aw_addr_r == `SPG_OFS_ROUTE && w_strb_r[0])
            route_r <= w_data_r[3:0];
    end

    // Bits of ports owned by a strobe are dropped, not stored
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            user_out_r <= `SPG_RST_UOUT;
        else if (wr_en && aw_addr_r == `SPG_OFS_UOUT && w_strb_r[0])
            user_out_r <= (user_out_r & route_r)
                          | (w_data_r[3:0] & ~route_r);
    end

    // Input ports come from pins and pass two flops first
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_meta_r <= 4'h0;
            in_sync_r <= 4'h0;
        end
        else
        begin
            in_meta_r <= in_port;
            in_sync_r <= in_meta_r;
        end
    end

    // Read path
    always_comb
    begin
        rd_data = 32'h00000000;
        rd_hit  = 1'b1;
        unique case (s_axi_araddr)
            `SPG_OFS_CH0:   rd_data = ch_ctrl_r[0];
            `SPG_OFS_CH1:   rd_data = ch_ctrl_r[1];
            `SPG_OFS_CH2:   rd_data = ch_ctrl_r[2];
            `SPG_OFS_CH3:   rd_data = ch_ctrl_r[3];
            `SPG_OFS_TICK:  rd_data = tick_sel_r;
            `SPG_OFS_ROUTE: rd_data = {28'h0000000, route_r};
            `SPG_OFS_UOUT:  rd_data = {28'h0000000, user_out_r};
            `SPG_OFS_INS:   rd_data = {20'h00000, busy, out_port, in_sync_r};
            default:        rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `SPG_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data;
            s_axi_rresp   <= rd_hit ? `SPG_RESP_OKAY : `SPG_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // Strobe channels
    for (genvar n = 0; n < `SPG_NCH; n++)
    begin : g_ch
        spg_state_t  state_r;
        logic [11:0] cnt_r;
        logic        en;
        logic [11:0] lag;
        logic [11:0] width;
        logic [7:0]  mult;
        logic        tick;
        logic        restart;
        logic        last;

        assign en      = ch_ctrl_r[n][`SPG_CH_EN];
        assign lag     = ch_ctrl_r[n][`SPG_CH_LAG_HI:`SPG_CH_LAG_LO];
        assign width   = ch_ctrl_r[n][`SPG_CH_WID_HI:`SPG_CH_WID_LO];
        assign mult    = (state_r == SPG_PULSE)
                         ? tick_sel_r[`SPG_TICK_DUR_HI:`SPG_TICK_DUR_LO]
                         : tick_sel_r[`SPG_TICK_DLY_HI:`SPG_TICK_DLY_LO];
        assign last    = tick && (cnt_r == `SPG_CNT_ONE);
        // Prescaler restarts at exposure and again when the pulse begins
        assign restart = exposure_start || (state_r == SPG_DELAY && last);
        assign active[n] = (state_r == SPG_PULSE);
        assign busy[n]   = (state_r != SPG_IDLE);

        spg_tick u_tick (
            .clk     (clk),
            .rst_n   (rst_n),
            .restart (restart),
            .mult    (mult),
            .tick    (tick)
        );

        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                state_r <= SPG_IDLE;
                cnt_r   <= `SPG_CNT_ZERO;
            end
            else if (!en)
            begin
                state_r <= SPG_IDLE;
            end
            else if (exposure_start)
            begin
                // Abort whatever runs and reload from the settings
                state_r <= SPG_DELAY;
                cnt_r   <= (lag == `SPG_CNT_ZERO) ? `SPG_CNT_ONE : lag;
            end
            else
            begin
                unique case (state_r)
                    SPG_IDLE:
                        cnt_r <= cnt_r;
                    SPG_DELAY:
                        if (last)
                        begin
                            state_r <= (width == `SPG_CNT_ZERO)
                                       ? SPG_IDLE : SPG_PULSE;
                            cnt_r   <= width;
                        end
                        else if (tick)
                            cnt_r <= 12'(cnt_r - `SPG_CNT_ONE);
                    SPG_PULSE:
                        if (last)
                            state_r <= SPG_IDLE;
                        else if (tick)
                            cnt_r <= 12'(cnt_r - `SPG_CNT_ONE);
                endcase
            end
        end

        // Strobe n reaches port n only; an idle strobe shows its inactive level
        assign port_nxt[n] = route_r[n]
            ? (active[n] == ch_ctrl_r[n][`SPG_CH_POL])
            : user_out_r[n];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            out_port <= 4'h0;
        else
            out_port <= port_nxt;
    end

endmodule // spg_top
`default_nettype wire

// ===== verif/spg_chk_sva.sv
// Port-level timing checker for the strobe pulse and port I/O block
`timescale 1ns/1ns
`default_nettype none
`include "spg_cfg.svh"
module spg_chk (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        exposure_start,
    input  wire logic [3:0]  in_port,
    input  wire logic [3:0]  out_port,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    input  wire logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    logic [3:0] in_prev_r;
    logic [1:0] in_quiet_r;
    logic [2:0] wr_age_r;
    logic [5:0] exp_age_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            in_prev_r <= 4'h0;
        else
            in_prev_r <= in_port;
    end
    // Saturating count of edges with the input ports unchanged
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            in_quiet_r <= 2'h0;
        else if (in_port != in_prev_r)
            in_quiet_r <= 2'h0;
        else if (in_quiet_r != 2'h3)
            in_quiet_r <= in_quiet_r + 2'h1;
    end
    // Register writes may move the ports at any time, so they open a quiet gap
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wr_age_r <= 3'h7;
        else if (s_axi_wvalid && s_axi_wready)
            wr_age_r <= 3'h0;
        else if (wr_age_r != 3'h7)
            wr_age_r <= wr_age_r + 3'h1;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            exp_age_r <= 6'h3f;
        else if (exposure_start)
            exp_age_r <= 6'h00;
        else if (exp_age_r != 6'h3f)
            exp_age_r <= exp_age_r + 6'h01;
    end
    // The write lands one edge after the handshake, so the answer is seen two edges on
    write_resp_a: assert property (wr_taken |-> ##2 s_axi_bvalid && s_axi_bresp ==
        ($past(s_axi_awaddr, 2) > 8'h1c || $past(s_axi_awaddr[1:0], 2) != 2'h0
        ? `SPG_RESP_SLVERR : `SPG_RESP_OKAY))
        else $error("write answer late or wrong");
    aw_refused_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("address taken again before response");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##0 s_axi_awready)
        else $error("write response not closed");
    read_resp_a: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read response not closed");
    unmapped_read_a: assert property (rd_taken ##0 s_axi_araddr > 8'h1c |=>
        s_axi_rresp == `SPG_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    input_sample_a: assert property (rd_taken ##0 (s_axi_araddr == `SPG_OFS_INS &&
        in_quiet_r == 2'h3) |=> s_axi_rdata[3:0] == $past(in_port, 3))
        else $error("input sample differs from ports");
    pulse_early_a: assert property (!$stable(out_port) && wr_age_r == 3'h7 |->
        exp_age_r <= 6'h03 || exp_age_r >= 6'h2d)
        else $error("port moved before first tick");
endmodule // spg_chk
bind spg_top spg_chk u_chk (.clk(clk), .rst_n(rst_n), .exposure_start(exposure_start),
    .in_port(in_port), .out_port(out_port), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// ===== verif/spg_lamp.sv
// Lamps and input lines standing at the far side of the strobe block
`timescale 1ns/1ns
`default_nettype none
module spg_lamp (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] out_port,
    input  wire logic [3:0] act_lvl,
    input  wire logic [3:0] in_drive,
    output logic      [3:0] in_port,
    output logic      [7:0] fire_cnt
);
    logic [3:0] seen_r;
    assign in_port = in_drive;
    // A lamp flashes once on each move of its port into its active level
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seen_r   <= 4'h0;
            fire_cnt <= 8'h00;
        end
        else
        begin
            seen_r   <= out_port;
            fire_cnt <= fire_cnt + 8'($countones(~(out_port ^ act_lvl) & (seen_r ^ act_lvl)));
        end
    end
endmodule // spg_lamp
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the strobe pulse and port I/O block
`timescale 1ns/1ns
`default_nettype none
`include "spg_cfg.svh"
module testbench;
    logic        clk, exposure_start = 1'b0, rst_n = 1'b0;
    logic [3:0]  in_port, out_port, in_drive = 4'h0, act_lvl = 4'h0;
    logic [7:0]  fire_cnt, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int          error_cnt = 0, num_checks = 0, cyc = 0;
    spg_top u_spg_top (.clk(clk), .rst_n(rst_n), .exposure_start(exposure_start),
        .in_port(in_port), .out_port(out_port), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    spg_lamp u_spg_lamp (.clk(clk), .rst_n(rst_n), .out_port(out_port), .act_lvl(act_lvl),
        .in_drive(in_drive), .in_port(in_port), .fire_cnt(fire_cnt));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Tick edges jitter by a cycle under the fractional prescaler
    function automatic logic [31:0] near(int seen, int exp);
        return {31'h0, (seen - exp <= 3) && (exp - seen <= 3)};
    endfunction
    function automatic int tk(int n, int m);
        return (n * (m + 1) * 6250 + 64) / 128;
    endfunction
    function automatic logic [31:0] cf(logic en, logic pol, logic [11:0] lag, logic [11:0] wid);
        return {en, pol, 6'h00, lag, wid};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w))
        begin
            @(posedge clk);
            aw = aw | (s_axi_awready === 1'b1);
            w = w | (s_axi_wready === 1'b1);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
        check($sformatf("reg %h", a), s_axi_rdata, exp);
    endtask
    task automatic expose();
        exposure_start <= 1'b1;
        @(posedge clk);
        exposure_start <= 1'b0;
    endtask
    task automatic run(input int ch, input logic [31:0] c, input int ed, input int ew,
                       input bit pre);
        int d;
        int w;
        logic [7:0] f0;
        act_lvl <= c[30] ? 4'(1 << ch) : 4'h0;
        wr(8'(ch * 4), c, `SPG_RESP_OKAY);
        repeat (3) @(posedge clk);
        f0 = fire_cnt;
        // Optional first exposure, cut short in its delay by the measured one
        if (pre) expose();
        if (pre) repeat (100) @(posedge clk);
        d = 0;
        w = 0;
        expose();
        while (out_port[ch] !== c[30] && d < 1200)
        begin
            @(posedge clk);
            d++;
        end
        while (out_port[ch] === c[30] && w < 1200)
        begin
            @(posedge clk);
            w++;
        end
        if (ed > 0) check("delay", near(d, ed), 32'h1);
        check("width", near(w, ew), 32'h1);
        check("flashes", 32'(8'(fire_cnt - f0)), 32'(ew > 0));
        wr(8'(ch * 4), 32'h0, `SPG_RESP_OKAY);
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 8; i++) rdc(8'(i * 4), 32'h0, `SPG_RESP_OKAY);
        rdc(8'h20, 32'h0, `SPG_RESP_SLVERR);
        wr(8'h20, 32'hffffffff, `SPG_RESP_SLVERR);
        wr(`SPG_OFS_CH3, 32'hffffffff, `SPG_RESP_OKAY);
        rdc(`SPG_OFS_CH3, 32'hc0ffffff, `SPG_RESP_OKAY);
        wr(`SPG_OFS_CH3, 32'h0, `SPG_RESP_OKAY);
        wr(`SPG_OFS_TICK, 32'hffffffff, `SPG_RESP_OKAY);
        rdc(`SPG_OFS_TICK, 32'h00ff00ff, `SPG_RESP_OKAY);
        wr(`SPG_OFS_TICK, 32'h0, `SPG_RESP_OKAY);
        $display("test registers done");
        wr(`SPG_OFS_UOUT, 32'ha, `SPG_RESP_OKAY);
        repeat (3) @(posedge clk);
        check("out_port", {28'h0, out_port}, 32'ha);
        wr(`SPG_OFS_ROUTE, 32'h1, `SPG_RESP_OKAY);
        wr(`SPG_OFS_UOUT, 32'h5, `SPG_RESP_OKAY);
        repeat (3) @(posedge clk);
        check("out_port", {28'h0, out_port}, 32'h5);
        rdc(`SPG_OFS_UOUT, 32'h4, `SPG_RESP_OKAY);
        in_drive <= 4'h9;
        repeat (4) @(posedge clk);
        rdc(`SPG_OFS_INS, 32'h59, `SPG_RESP_OKAY);
        in_drive <= 4'h6;
        repeat (4) @(posedge clk);
        rdc(`SPG_OFS_INS, 32'h56, `SPG_RESP_OKAY);
        $display("test user io done");
        wr(`SPG_OFS_ROUTE, 32'hf, `SPG_RESP_OKAY);
        for (int ch = 0; ch < 4; ch++)
            run(ch, cf(1, ch[0], 2, 3), tk(2, 0) + 1, tk(3, 0), 0);
        run(1, cf(0, 1, 2, 3), 0, 0, 0);
        run(2, cf(1, 1, 0, 0), 0, 0, 0);
        run(2, cf(1, 1, 0, 2), tk(1, 0) + 1, tk(2, 0), 0);
        wr(`SPG_OFS_TICK, 32'h00010002, `SPG_RESP_OKAY);
        run(0, cf(1, 1, 2, 2), tk(2, 2) + 1, tk(2, 1), 0);
        wr(`SPG_OFS_TICK, 32'h0, `SPG_RESP_OKAY);
        run(0, cf(1, 1, 4, 2), tk(4, 0) + 1, tk(2, 0), 1);
        wr(`SPG_OFS_ROUTE, 32'h7, `SPG_RESP_OKAY);
        run(3, cf(1, 1, 1, 1), 0, 0, 0);
        $display("test strobes done");
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
